// >>> logic/fbl_pkg.sv
// Purpose: constants and types for the flash boot and probe lock block
// Assumes: 32-bit apb, 10 MHz system clock
// Notes: offsets are byte addresses, one aligned word per register
package fbl_pkg;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CODE = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_PROT = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [31:0] UNLOCK_CODE = 32'h0000_00C5;
	localparam logic [3:0] STRB_WORD = 4'hF;
	// mode register fields
	localparam int INHIBIT_BIT = 0;
	localparam int REENABLE_BIT = 1;
	localparam int RDPROT_BIT = 2;
	localparam logic [2:0] MODE_RST = 3'h1;
	// control register fields
	localparam int USERBOOT_BIT = 0;
	localparam int GEAR_LSB = 4;
	localparam logic [1:0] GEAR_DIV8 = 2'h3;
	// command register fields
	localparam int OP_LSB = 0;
	localparam int BLK_LSB = 4;
	localparam logic [1:0] OP_PROG = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_UNPROT = 2'h3;
	// status register fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_BOOT_BIT = 1;
	localparam int ST_INH_BIT = 2;
	localparam int ST_PALL_BIT = 3;
	localparam int NBLK = 8;
	localparam int BLK_PER_ARRAY = 4;
	localparam int BANK_ADDR_BIT = 2;
	localparam int BLK_ADDR_LSB = 17;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int PROG_MS = 500;
	localparam int ERASE_MS = 100;
	localparam int PROG_CYC = PROG_MS * CYC_PER_MS;
	localparam int ERASE_CYC = ERASE_MS * CYC_PER_MS;
	localparam int CNT_W = 23;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PROG = 4'b0010,
		ST_ERASE = 4'b0100,
		ST_UNPROT = 4'b1000
	} fbl_op_state_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} fbl_apb_req_t;
	typedef struct packed {
		logic req;
		logic [19:0] addr;
	} fbl_rd_req_t;
endpackage

// >>> logic/fbl_flash_lock.sv
// Purpose: flash boot mode, protection and debug probe lock control
// Assumes: flash arrays, cpu and probe read paths sit outside; apb slave
// Notes: por resets every register but the boot pin path; rst keeps the probe lock registers
// Behaviour
// - eight 128 kB blocks over two 512 kB arrays, each written alone
// - cpu flash accesses use a 32-bit data path
// - reads interleave between the two flash arrays
// - boot pin level sampled during reset picks single chip or single boot
// - clock gear is divide by eight after reset
// - probe inhibit active refuses all debug probe operation; here only probe reads are refused, probe_op_req is left unused
// - probe read protection blocks every probe read of flash
// - inhibit lifts only after inhibit bit cleared and unlock code written
// - reenable bit set then unlock code written restores probe protection
// - probe lock registers reset only on power-on reset
// - read protection keeps external tools from reading flash
// - rewrite protection set and cleared only by software commands; here por clears it as well
// - whole protection becomes active once every area is protected
// - removing protection erases flash first, then clears protection
// - flash unreadable while erase or program runs
// - user boot mode inhibits every interrupt including nmi
// - any reset returns flash to normal mode
// - block program about 0.5 s, block erase about 100 ms
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module fbl_flash_lock #(
	parameter int PROG_CYCLES = fbl_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = fbl_pkg::ERASE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic boot_pin,
	input wire fbl_pkg::fbl_apb_req_t apb_req,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire fbl_pkg::fbl_rd_req_t cpu_rd,
	input wire fbl_pkg::fbl_rd_req_t probe_rd,
	input wire logic probe_op_req,
	output logic cpu_rd_ok,
	output logic cpu_rd_deny,
	output logic rd_bank,
	output logic probe_rd_ok,
	output logic probe_rd_deny,
	output logic probe_enable,
	output logic single_boot,
	output logic [1:0] clk_gear,
	output logic irq_inhibit,
	output logic flash_busy,
	output logic [2:0] op_block,
	output logic read_protect
);
	import fbl_pkg::*;

	function automatic logic bank_of(input logic [19:0] a);
		bank_of = a[BANK_ADDR_BIT];
	endfunction

	logic boot_s1_r, boot_s2_r;
	logic boot_mode_r;
	logic [2:0] mode_r;
	logic inhibit_r;
	logic userboot_r;
	logic [1:0] gear_r;
	logic [7:0] prot_r;
	logic [7:0] prot_nxt;
	fbl_op_state_t st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [2:0] blk_r;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic cpu_ok_r, cpu_deny_r, bank_r;
	logic prb_ok_r, prb_deny_r;
	logic probe_en_r;
	logic busy_r;
	logic prot_all_r;

	// apb decode
	wire setup = apb_req.psel & ~apb_req.penable;
	wire done = apb_req.psel & apb_req.penable & pready_r;
	wire wr = done & apb_req.pwrite & ~pslverr_r;
	wire full = apb_req.pstrb == STRB_WORD;
	wire a_mode = apb_req.paddr == OFS_MODE;
	wire a_code = apb_req.paddr == OFS_CODE;
	wire a_ctrl = apb_req.paddr == OFS_CTRL;
	wire a_prot = apb_req.paddr == OFS_PROT;
	wire a_cmd = apb_req.paddr == OFS_CMD;
	wire a_stat = apb_req.paddr == OFS_STAT;
	wire mapped = a_mode | a_code | a_ctrl | a_prot | a_cmd | a_stat;
	// partial writes to the lock code register are refused
	wire bad_strb = apb_req.pwrite & a_code & ~full;
	wire code_ok = wr & a_code & (apb_req.pwdata == UNLOCK_CODE);
	wire lift = code_ok & ~mode_r[INHIBIT_BIT];
	wire relock = code_ok & mode_r[REENABLE_BIT];
	wire idle = st_r == ST_IDLE;
	wire prot_all = &prot_r;
	wire [1:0] cmd_op = apb_req.pwdata[OP_LSB +: 2];
	wire [2:0] cmd_blk = apb_req.pwdata[BLK_LSB +: 3];
	wire cmd_wr = wr & a_cmd & idle;
	wire go_prog = cmd_wr & (cmd_op == OP_PROG) & ~prot_r[cmd_blk];
	wire go_erase = cmd_wr & (cmd_op == OP_ERASE) & ~prot_r[cmd_blk];
	wire go_unprot = cmd_wr & (cmd_op == OP_UNPROT);
	wire cnt_end = cnt_r == '0;

	logic [31:0] rd_word;
	always_comb begin
		rd_word = '0;
		if (a_mode) begin
			rd_word[2:0] = mode_r;
		end else if (a_ctrl) begin
			rd_word[USERBOOT_BIT] = userboot_r;
			rd_word[GEAR_LSB +: 2] = gear_r;
		end else if (a_prot) begin
			rd_word[NBLK-1:0] = prot_r;
		end else if (a_cmd) begin
			rd_word[BLK_LSB +: 3] = blk_r;
		end else if (a_stat) begin
			rd_word[ST_BUSY_BIT] = ~idle;
			rd_word[ST_BOOT_BIT] = boot_mode_r;
			rd_word[ST_INH_BIT] = inhibit_r;
			rd_word[ST_PALL_BIT] = prot_all;
		end
	end

	// apb slave: one wait-free access, answer registered at setup
	always_ff @(posedge sys_clk) begin
		if (rst | por) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= setup;
			// error stands only with its one access cycle
			pslverr_r <= setup & (~mapped | bad_strb);
			if (setup) begin
				prdata_r <= rd_word;
			end
		end
	end

	// boot pin crosses in from the board
	always_ff @(posedge sys_clk) begin
		boot_s1_r <= boot_pin;
		boot_s2_r <= boot_s1_r;
	end

	// mode follows the pin while reset is held, frozen at release
	always_ff @(posedge sys_clk) begin
		if (rst | por) begin
			boot_mode_r <= boot_s2_r;
		end
	end

	// lock state survives a normal reset
	always_ff @(posedge sys_clk) begin
		if (por) begin
			mode_r <= MODE_RST;
			inhibit_r <= 1'b1;
			probe_en_r <= 1'b0;
		end else begin
			if (wr & a_mode) begin
				mode_r <= apb_req.pwdata[2:0];
			end
			// enable is its own flop so the probe side sees no gate after it
			if (relock) begin
				inhibit_r <= 1'b1;
				probe_en_r <= 1'b0;
			end else if (lift) begin
				inhibit_r <= 1'b0;
				probe_en_r <= 1'b1;
			end
		end
	end

	// any reset leaves user boot and restores the slow gear
	always_ff @(posedge sys_clk) begin
		if (rst | por) begin
			userboot_r <= 1'b0;
			gear_r <= GEAR_DIV8;
		end else if (wr & a_ctrl) begin
			userboot_r <= apb_req.pwdata[USERBOOT_BIT];
			gear_r <= apb_req.pwdata[GEAR_LSB +: 2];
		end
	end

	// block protection and the operation sequencer
	always_comb begin
		prot_nxt = prot_r;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		if (wr & a_prot & idle) begin
			// software may only add protection; removal goes through erase
			prot_nxt = prot_r | apb_req.pwdata[NBLK-1:0];
		end
		case (st_r)
			ST_IDLE: begin
				if (go_prog) begin
					st_nxt = ST_PROG;
					cnt_nxt = CNT_W'(PROG_CYCLES - 1);
				end else if (go_erase) begin
					st_nxt = ST_ERASE;
					cnt_nxt = CNT_W'(ERASE_CYCLES - 1);
				end else if (go_unprot) begin
					st_nxt = ST_UNPROT;
					cnt_nxt = CNT_W'(ERASE_CYCLES - 1);
				end
			end
			ST_PROG, ST_ERASE: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_end) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_UNPROT: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_end) begin
					st_nxt = ST_IDLE;
					prot_nxt = '0;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// a reset aborts any running operation
	always_ff @(posedge sys_clk) begin
		if (rst | por) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			blk_r <= '0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			// taken from the next state so busy keeps step with st_r
			busy_r <= st_nxt != ST_IDLE;
			if (cmd_wr) begin
				blk_r <= cmd_blk;
			end
		end
	end

	// protection bits are nonvolatile in the array, so of the two resets only por clears them; an unprotect clears them too
	always_ff @(posedge sys_clk) begin
		if (por) begin
			prot_r <= '0;
			prot_all_r <= 1'b0;
		end else begin
			prot_r <= prot_nxt;
			// registered copy for the output, same cycle as prot_r
			prot_all_r <= &prot_nxt;
		end
	end

	// read gating for cpu and probe paths
	wire prb_block = inhibit_r | mode_r[RDPROT_BIT] | prot_all | ~idle;
	always_ff @(posedge sys_clk) begin
		if (rst | por) begin
			cpu_ok_r <= 1'b0;
			cpu_deny_r <= 1'b0;
			bank_r <= 1'b0;
			prb_ok_r <= 1'b0;
			prb_deny_r <= 1'b0;
		end else begin
			cpu_ok_r <= cpu_rd.req & idle;
			cpu_deny_r <= cpu_rd.req & ~idle;
			if (cpu_rd.req) begin
				bank_r <= bank_of(cpu_rd.addr);
			end
			prb_ok_r <= probe_rd.req & ~prb_block;
			prb_deny_r <= probe_rd.req & prb_block;
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign cpu_rd_ok = cpu_ok_r;
	assign cpu_rd_deny = cpu_deny_r;
	assign rd_bank = bank_r;
	assign probe_rd_ok = prb_ok_r;
	assign probe_rd_deny = prb_deny_r;
	assign probe_enable = probe_en_r;
	assign single_boot = boot_mode_r;
	assign clk_gear = gear_r;
	assign irq_inhibit = userboot_r;
	assign flash_busy = busy_r;
	assign op_block = blk_r;
	assign read_protect = prot_all_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst | por);

	AST_RELOCK: assert property (relock |=> inhibit_r)
		else $error("probe lock not restored after code");
	AST_LIFT: assert property (lift & ~relock |=> ~inhibit_r)
		else $error("probe inhibit not lifted");
	AST_KEEP_INH: assert property (~code_ok |=> inhibit_r == $past(inhibit_r))
		else $error("probe inhibit changed without code");
	AST_PROBE_DENY: assert property (probe_rd.req & inhibit_r |=> probe_rd_deny & ~probe_rd_ok)
		else $error("probe read allowed while inhibited");
	AST_RDPROT: assert property (probe_rd.req & mode_r[RDPROT_BIT] |=> ~probe_rd_ok)
		else $error("probe read allowed under read protection");
	AST_BUSY_READ: assert property (cpu_rd.req & ~idle |=> cpu_rd_deny & ~cpu_rd_ok)
		else $error("flash read served during operation");
	AST_BANK: assert property (cpu_rd.req |=> rd_bank == $past(cpu_rd.addr[BANK_ADDR_BIT]))
		else $error("read bank not taken from address");
	AST_IRQ: assert property (wr & a_ctrl |=> irq_inhibit == $past(apb_req.pwdata[USERBOOT_BIT]))
		else $error("interrupts not inhibited in user boot");
	AST_UNPROT: assert property (go_unprot |=> flash_busy [*8])
		else $error("protection cleared before erase");
	AST_PROT_HOLD: assert property (st_r == ST_UNPROT & ~cnt_end |=> prot_r == $past(prot_r))
		else $error("protection dropped during erase");
	AST_STRB: assert property (setup & bad_strb |=> pslverr)
		else $error("partial write to lock code not refused");
	AST_BOOT: assert property ($rose(flash_busy) |-> single_boot == $past(single_boot))
		else $error("boot mode moved after reset");
	AST_BUSY_REG: assert property (flash_busy == ~idle)
		else $error("busy output out of step with sequencer");
	AST_EN_REG: assert property (probe_enable == ~inhibit_r)
		else $error("probe enable out of step with inhibit");
	AST_PALL_REG: assert property (read_protect == prot_all)
		else $error("read protect out of step with block protects");
	AST_GEAR_RST: assert property ($fell(rst) |-> clk_gear == GEAR_DIV8)
		else $error("clock gear not slow after reset");
	AST_UB_RST: assert property ($fell(rst) |-> ~irq_inhibit)
		else $error("user boot kept over reset");
	AST_PROG_REFUSE: assert property (cmd_wr & (cmd_op != OP_UNPROT) & prot_r[cmd_blk] |=> ~flash_busy)
		else $error("operation started on protected block");
	AST_OP_BLOCK: assert property (cmd_wr |=> op_block == $past(cmd_blk))
		else $error("command block not taken");
	AST_PROT_KEEP: assert property (st_r != ST_UNPROT |=> (prot_r & $past(prot_r)) == $past(prot_r))
		else $error("block protect cleared outside unprotect");
endmodule // fbl_flash_lock

// >>> tb/fbl_probe_model.sv
// Purpose: debug probe and board boot pin facing the flash lock block
// Assumes: bench moves go and address by nba just after a rising edge
// Notes: address lines carry inverted junk while no read is asked for
`timescale 1ns/1ns
module fbl_probe_model (
	input wire logic boot_lvl,
	input wire logic rd_go,
	input wire logic [19:0] rd_addr,
	output logic boot_pin,
	output fbl_pkg::fbl_rd_req_t probe_rd,
	output logic probe_op_req
);
	import fbl_pkg::*;
	// bench moves the level only while reset is held
	assign boot_pin = boot_lvl;
	assign probe_rd = '{req: rd_go, addr: rd_go ? rd_addr : ~rd_addr};
	assign probe_op_req = rd_go;
endmodule // fbl_probe_model

// >>> tb/fbl_flash_lock_tb.sv
// Purpose: self-checking bench for the flash boot and probe lock block
// Assumes: short program and erase counts so the run stays brief
// Notes: registers reached over apb; probe reads go through the partner model
`timescale 1ns/1ns
module fbl_flash_lock_tb;
	import fbl_pkg::*;
	localparam int PC = 20;
	localparam int EC = 10;
	logic sys_clk = 0, rst = 1, por = 1, boot_lvl = 1, rd_go = 0, er;
	logic [19:0] rd_addr = '0, ra;
	logic [31:0] rd, code;
	fbl_apb_req_t req = '0;
	fbl_rd_req_t cpu_rd = '0, probe_rd;
	logic pready, pslverr, cpu_rd_ok, cpu_rd_deny, rd_bank, probe_rd_ok, probe_rd_deny, probe_enable;
	logic single_boot, irq_inhibit, flash_busy, read_protect, boot_pin, probe_op_req;
	logic [31:0] prdata;
	logic [1:0] clk_gear;
	logic [2:0] op_block, blk;
	int n_mismatch = 0, samples_checked = 0, n;
	always #50 sys_clk = ~sys_clk;
	fbl_flash_lock #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_dut (.sys_clk(sys_clk), .rst(rst), .por(por),
		.boot_pin(boot_pin), .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cpu_rd(cpu_rd), .probe_rd(probe_rd), .probe_op_req(probe_op_req), .cpu_rd_ok(cpu_rd_ok),
		.cpu_rd_deny(cpu_rd_deny), .rd_bank(rd_bank), .probe_rd_ok(probe_rd_ok), .probe_rd_deny(probe_rd_deny),
		.probe_enable(probe_enable), .single_boot(single_boot), .clk_gear(clk_gear), .irq_inhibit(irq_inhibit),
		.flash_busy(flash_busy), .op_block(op_block), .read_protect(read_protect));
	fbl_probe_model i_probe (.boot_lvl(boot_lvl), .rd_go(rd_go), .rd_addr(rd_addr), .boot_pin(boot_pin),
		.probe_rd(probe_rd), .probe_op_req(probe_op_req));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		// pready is read before this edge's updates land; only the watchdog ends a hang
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, STRB_WORD);
	endtask
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// one read cycle on either path, answer looked at in the cycle after
	task automatic rd_path(input logic probe, input logic [19:0] a, input logic ok, input string nm);
		@(posedge sys_clk);
		if (probe)
			{rd_go, rd_addr} <= {1'b1, a};
		else
			cpu_rd <= '{req: 1'b1, addr: a};
		@(posedge sys_clk);
		rd_go <= 1'b0;
		cpu_rd.req <= 1'b0;
		#1;
		chk(nm, probe ? {probe_rd_ok, probe_rd_deny} : {cpu_rd_ok, cpu_rd_deny}, {ok, !ok});
	endtask
	function automatic logic probe_ok(input logic inh, input logic rdp, input logic allp, input logic busy);
		return !(inh | rdp | allp | busy);
	endfunction
	task automatic busy_len(output int c);
		c = 0;
		repeat (100) begin
			#1;
			if (flash_busy)
				c++;
			@(posedge sys_clk);
		end
	endtask
	initial begin
		#(5000 * 100);
		n_mismatch++;
		close_out();
	end
	initial begin
		void'($urandom(58));
		repeat (5) @(posedge sys_clk);
		{por, rst} <= 2'b00;
		settle();
		chk("gear", clk_gear, 2'h3);
		chk("boot", single_boot, 1'b1);
		rd_path(1'b1, 20'h0_0100, probe_ok(1, 0, 0, 0), "probe_locked");
		$display("test reset done");
		code = $urandom;
		if (code == UNLOCK_CODE)
			code = code ^ 32'h0000_0001;
		wr(OFS_CODE, UNLOCK_CODE);
		apb(1'b0, OFS_STAT, '0, STRB_WORD);
		chk("inh_one_step", rd[ST_INH_BIT], 1'b1);
		wr(OFS_MODE, '0);
		wr(OFS_CODE, code);
		apb(1'b0, OFS_STAT, '0, STRB_WORD);
		chk("inh_bad_code", rd[ST_INH_BIT], 1'b1);
		wr(OFS_CODE, UNLOCK_CODE);
		settle();
		chk("probe_en", probe_enable, 1'b1);
		rd_path(1'b1, 20'h4_0000, probe_ok(0, 0, 0, 0), "probe_free");
		wr(OFS_MODE, 32'h0000_0001 << RDPROT_BIT);
		rd_path(1'b1, 20'h4_0000, probe_ok(0, 1, 0, 0), "probe_rdprot");
		wr(OFS_MODE, '0);
		apb(1'b1, OFS_CODE, UNLOCK_CODE, 4'h3);
		chk("half_word", er, 1'b1);
		apb(1'b0, 8'h20, '0, STRB_WORD);
		chk("unmapped", {er, rd}, {1'b1, 32'h0000_0000});
		$display("test lock done");
		wr(OFS_CTRL, 32'h0000_0001 << USERBOOT_BIT);
		settle();
		chk("irq_off", irq_inhibit, 1'b1);
		chk("gear_set", clk_gear, 2'h0);
		@(posedge sys_clk);
		{rst, boot_lvl} <= 2'b10;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		settle();
		chk("irq_back", irq_inhibit, 1'b0);
		chk("boot_new", single_boot, 1'b0);
		chk("gear_rst", clk_gear, 2'h3);
		chk("kept_en", probe_enable, 1'b1);
		apb(1'b0, OFS_MODE, '0, STRB_WORD);
		chk("kept_mode", rd, 32'h0000_0000);
		$display("test reset keep done");
		blk = 3'($urandom_range(7, 0));
		wr(OFS_CMD, 32'(OP_PROG) | (32'(blk) << BLK_LSB));
		busy_len(n);
		chk("prog_len", n, PC);
		chk("op_block", op_block, blk);
		wr(OFS_CMD, 32'(OP_ERASE) | (32'(blk ^ 3'h1) << BLK_LSB));
		rd_path(1'b0, 20'h0_0010, 1'b0, "cpu_busy");
		rd_path(1'b1, 20'h0_0010, probe_ok(0, 0, 0, 1), "probe_busy");
		repeat (EC) @(posedge sys_clk);
		ra = 20'($urandom);
		rd_path(1'b0, ra, 1'b1, "cpu_ok");
		chk("bank", rd_bank, ra[BANK_ADDR_BIT]);
		rd_path(1'b0, ra ^ (20'h0_0001 << BANK_ADDR_BIT), 1'b1, "cpu_ok2");
		chk("bank_other", rd_bank, !ra[BANK_ADDR_BIT]);
		$display("test program done");
		wr(OFS_PROT, 32'h0000_007F);
		settle();
		chk("part_prot", read_protect, 1'b0);
		wr(OFS_PROT, 32'h0000_0080);
		settle();
		chk("all_prot", read_protect, 1'b1);
		rd_path(1'b1, 20'h0_0200, probe_ok(0, 0, 1, 0), "probe_allprot");
		wr(OFS_CMD, 32'(OP_PROG) | (32'(blk) << BLK_LSB));
		settle();
		chk("prot_refuse", flash_busy, 1'b0);
		wr(OFS_CMD, 32'(OP_UNPROT));
		busy_len(n);
		chk("unprot_len", n, EC);
		chk("unprot_done", read_protect, 1'b0);
		wr(OFS_MODE, 32'h0000_0001 << REENABLE_BIT);
		wr(OFS_CODE, UNLOCK_CODE);
		settle();
		chk("relock", probe_enable, 1'b0);
		$display("test protect done");
		close_out();
	end
endmodule // fbl_flash_lock_tb
